/* raster_timing_cfg.svh */
`ifndef RASTER_TIMING_CFG_SVH
`define RASTER_TIMING_CFG_SVH

`define IDX_HTOTAL      5'h00
`define IDX_HDISP       5'h01
`define IDX_HSYNC_POS   5'h02
`define IDX_SYNC_WIDTH  5'h03
`define IDX_VTOTAL      5'h04
`define IDX_VADJUST     5'h05
`define IDX_VDISP       5'h06
`define IDX_VSYNC_POS   5'h07
`define IDX_INTERLACE   5'h08
`define IDX_MAX_SCAN    5'h09
`define IDX_CUR_START   5'h0A
`define IDX_CUR_END     5'h0B
`define IDX_START_HI    5'h0C
`define IDX_START_LO    5'h0D
`define IDX_CUR_HI      5'h0E
`define IDX_CUR_LO      5'h0F
`define IDX_PEN_HI      5'h10
`define IDX_PEN_LO      5'h11

`define CUR_BLINK_RATE_BIT 5
`define CUR_BLINK_EN_BIT   6
`define VSYNC_LINES        5'h10
`define BLINK_FAST_FIELDS  5'h10
`define BLINK_SLOW_FIELDS  6'h20
`define IL_VIDEO_MODE      2'h1
`define HS_WIDTH_LSB       0
`define HS_WIDTH_MSB       3

`endif

/* raster_timing_pkg.sv */
package raster_timing_pkg;

   typedef logic [13:0] addr14_t;

   typedef struct packed {
      logic [7:0] htotal;
      logic [7:0] hdisp;
      logic [7:0] hsync_pos;
      logic [7:0] sync_width;
      logic [6:0] vtotal;
      logic [4:0] vadjust;
      logic [6:0] vdisp;
      logic [6:0] vsync_pos;
      logic [5:0] interlace;
      logic [4:0] max_scan;
      logic [6:0] cur_start;
      logic [4:0] cur_end;
      addr14_t    start_addr;
      addr14_t    cur_addr;
   } timing_regs_s;

   typedef struct packed {
      logic       chip_select_n;
      logic       register_select;
      logic       read_not_write;
      logic [7:0] data;
   } host_bus_s;

   typedef enum logic [1:0] {
      V_ACTIVE,
      V_ADJUST
   } vphase_e;

endpackage

/* host_register_port.sv */
`timescale 1ns/1ps
`include "raster_timing_cfg.svh"
module host_register_port (
   // Host strobe and bus
   input  wire logic                          bus_strobe_i,
   input  wire raster_timing_pkg::host_bus_s  bus_i,
   // Pen capture from raster domain
   input  wire raster_timing_pkg::addr14_t    pen_capture_i,
   // Register contents and read data
   output raster_timing_pkg::timing_regs_s    regs_o,
   output logic [7:0]                         read_data_o
);
   import raster_timing_pkg::*;

   logic [4:0] index_pointer;

   // Own strobe domain; no reset so control registers survive reset
   always_ff @(negedge bus_strobe_i) begin
      if (!bus_i.chip_select_n && !bus_i.read_not_write) begin
         if (!bus_i.register_select) begin
            index_pointer <= bus_i.data[4:0];
         end else begin
            case (index_pointer)
               `IDX_HTOTAL:     regs_o.htotal     <= bus_i.data;
               `IDX_HDISP:      regs_o.hdisp      <= bus_i.data;
               `IDX_HSYNC_POS:  regs_o.hsync_pos  <= bus_i.data;
               `IDX_SYNC_WIDTH: regs_o.sync_width <= bus_i.data;
               `IDX_VTOTAL:     regs_o.vtotal     <= bus_i.data[6:0];
               `IDX_VADJUST:    regs_o.vadjust    <= bus_i.data[4:0];
               `IDX_VDISP:      regs_o.vdisp      <= bus_i.data[6:0];
               `IDX_VSYNC_POS:  regs_o.vsync_pos  <= bus_i.data[6:0];
               `IDX_INTERLACE:  regs_o.interlace  <= bus_i.data[5:0];
               `IDX_MAX_SCAN:   regs_o.max_scan   <= bus_i.data[4:0];
               `IDX_CUR_START:  regs_o.cur_start  <= bus_i.data[6:0];
               `IDX_CUR_END:    regs_o.cur_end    <= bus_i.data[4:0];
               `IDX_START_HI:   regs_o.start_addr[13:8] <= bus_i.data[5:0];
               `IDX_START_LO:   regs_o.start_addr[7:0]  <= bus_i.data;
               `IDX_CUR_HI:     regs_o.cur_addr[13:8]   <= bus_i.data[5:0];
               `IDX_CUR_LO:     regs_o.cur_addr[7:0]    <= bus_i.data;
               default: ;
            endcase
         end
      end
   end

   // Readable registers only; others read as zero
   always_comb begin
      read_data_o = 8'h00;
      case (index_pointer)
         `IDX_CUR_HI: read_data_o = {2'h0, regs_o.cur_addr[13:8]};
         `IDX_CUR_LO: read_data_o = regs_o.cur_addr[7:0];
         `IDX_PEN_HI: read_data_o = {2'h0, pen_capture_i[13:8]};
         `IDX_PEN_LO: read_data_o = pen_capture_i[7:0];
         default:     read_data_o = 8'h00;
      endcase
   end
endmodule

/* cursor_blinker.sv */
`timescale 1ns/1ps
`include "raster_timing_cfg.svh"
module cursor_blinker (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // Field event and mode
   input  wire logic       field_end_i,
   input  wire logic [1:0] mode_i,
   // Blink phase
   output logic            visible_o
);
   logic [5:0] field_count;

   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         field_count <= 6'h00;
      end else if (field_end_i) begin
         field_count <= field_count + 6'h01;
      end
   end

   // Bit 6 enables blink, bit 5 halves its rate; bit 5 alone hides the cursor
   always_comb begin
      case (mode_i)
         2'h0:    visible_o = 1'b1;
         2'h1:    visible_o = 1'b0;
         2'h2:    visible_o = field_count[4];
         default: visible_o = field_count[5];
      endcase
   end
endmodule

/* crt_raster_timing_controller.sv */
`timescale 1ns/1ps
`include "raster_timing_cfg.svh"
module crt_raster_timing_controller (
   // Character clock and reset
   input  wire logic                         ref_clk_i,
   input  wire logic                         rst_i,
   // Host register port
   input  wire logic                         bus_strobe_i,
   input  wire raster_timing_pkg::host_bus_s bus_i,
   output logic [7:0]                        data_o,
   output logic                              data_oe_o,
   // Light pen
   input  wire logic                         light_pen_strobe_i,
   // Display outputs
   output logic                              horizontal_sync_o,
   output logic                              vertical_sync_o,
   output logic                              active_area_flag_o,
   output raster_timing_pkg::addr14_t        refresh_address_o,
   output logic [4:0]                        char_line_index_o,
   output logic                              cursor_o
);
   import raster_timing_pkg::*;

   timing_regs_s regs;
   addr14_t      pen_capture;
   logic [7:0]   read_data;
   logic         blink_visible;

   logic [7:0]   hcount;
   logic [3:0]   hsync_count;
   logic         hsync_active;
   logic         hdisp_active;
   logic [4:0]   scan_line;
   logic [6:0]   row_count;
   logic [4:0]   adjust_count;
   logic [4:0]   vsync_count;
   logic         vsync_active;
   logic         vdisp_active;
   logic         odd_field;
   vphase_e      vphase;
   addr14_t      line_addr;
   addr14_t      row_start;
   addr14_t      next_row_start;
   logic [2:0]   pen_sync;
   logic         strobe_meta;
   logic         strobe_sync;
   logic [1:0]   read_sync;
   logic         field_end;
   logic         line_end;
   logic         row_end;
   logic         frame_end;

   host_register_port u_port (
      .bus_strobe_i  (bus_strobe_i),
      .bus_i         (bus_i),
      .pen_capture_i (pen_capture),
      .regs_o        (regs),
      .read_data_o   (read_data)
   );

   cursor_blinker u_blink (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .field_end_i (field_end),
      .mode_i      (regs.cur_start[`CUR_BLINK_EN_BIT:`CUR_BLINK_RATE_BIT]),
      .visible_o   (blink_visible)
   );

   function automatic logic in_range(input logic [4:0] v, input logic [4:0] lo,
                                     input logic [4:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   // Counts are relative to leftmost character and top row
   assign line_end  = (hcount == regs.htotal);
   assign row_end   = line_end && (scan_line == regs.max_scan);
   assign frame_end = (vphase == V_ACTIVE) ? (row_end && (row_count == regs.vtotal)
                                               && (regs.vadjust == 5'h00))
                                            : (line_end && (adjust_count == regs.vadjust
                                                            - 5'h01));
   assign field_end = frame_end;

   // Horizontal counter
   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hcount <= 8'h00;
      end else if (line_end) begin
         hcount <= 8'h00;
      end else begin
         hcount <= hcount + 8'h01;
      end
   end

   // Horizontal display and sync from comparisons
   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hdisp_active <= 1'b0;
         hsync_active <= 1'b0;
         hsync_count  <= 4'h0;
      end else begin
         if (line_end) begin
            hdisp_active <= (regs.hdisp != 8'h00);
         end else if (hcount + 8'h01 == regs.hdisp) begin
            hdisp_active <= 1'b0;
         end
         // Zero width gives no sync at all
         if (hcount + 8'h01 == regs.hsync_pos
             && regs.sync_width[`HS_WIDTH_MSB:`HS_WIDTH_LSB] != 4'h0) begin
            hsync_active <= 1'b1;
            hsync_count  <= 4'h1;
         end else if (hsync_active) begin
            if (hsync_count == regs.sync_width[`HS_WIDTH_MSB:`HS_WIDTH_LSB]) begin
               hsync_active <= 1'b0;
            end
            hsync_count <= hsync_count + 4'h1;
         end
      end
   end

   // Scan line and row counters
   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scan_line    <= 5'h00;
         row_count    <= 7'h00;
         adjust_count <= 5'h00;
         vphase       <= V_ACTIVE;
         odd_field    <= 1'b0;
      end else if (frame_end) begin
         scan_line    <= 5'h00;
         row_count    <= 7'h00;
         adjust_count <= 5'h00;
         vphase       <= V_ACTIVE;
         odd_field    <= ~odd_field;
      end else if (vphase == V_ADJUST) begin
         if (line_end) begin
            adjust_count <= adjust_count + 5'h01;
            scan_line    <= scan_line + 5'h01;
         end
      end else if (row_end) begin
         scan_line <= 5'h00;
         if (row_count == regs.vtotal) begin
            vphase <= V_ADJUST;
         end else begin
            row_count <= row_count + 7'h01;
         end
      end else if (line_end) begin
         scan_line <= scan_line + 5'h01;
      end
   end

   // Vertical display and fixed-width vertical sync
   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         vdisp_active <= 1'b0;
         vsync_active <= 1'b0;
         vsync_count  <= 5'h00;
      end else begin
         if (frame_end) begin
            vdisp_active <= (regs.vdisp != 7'h00);
         end else if (row_end && row_count + 7'h01 == regs.vdisp) begin
            vdisp_active <= 1'b0;
         end
         if (row_end && vphase == V_ACTIVE && row_count + 7'h01 == regs.vsync_pos) begin
            vsync_active <= 1'b1;
            vsync_count  <= 5'h00;
         end else if (vsync_active && line_end) begin
            if (vsync_count == `VSYNC_LINES - 5'h01) begin
               vsync_active <= 1'b0;
            end
            vsync_count <= vsync_count + 5'h01;
         end
      end
   end

   // Linear address: same row start replayed for every scan line
   assign next_row_start = row_start + {6'h00, regs.hdisp};

   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         row_start <= 14'h0000;
         line_addr <= 14'h0000;
      end else if (frame_end) begin
         row_start <= regs.start_addr;
         line_addr <= regs.start_addr;
      end else if (row_end) begin
         row_start <= next_row_start;
         line_addr <= next_row_start;
      end else if (line_end) begin
         line_addr <= row_start;
      end else begin
         line_addr <= line_addr + 14'h0001;
      end
   end

   // Pen strobe is asynchronous, two flops before edge detection
   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         strobe_meta <= 1'b0;
         strobe_sync <= 1'b0;
         pen_sync    <= 3'h0;
      end else begin
         strobe_meta <= light_pen_strobe_i;
         strobe_sync <= strobe_meta;
         pen_sync    <= {pen_sync[1:0], strobe_sync};
      end
   end

   // Capture register survives reset like the other registers
   always_ff @(negedge ref_clk_i) begin
      if (pen_sync[0] && !pen_sync[1]) begin
         pen_capture <= line_addr;
      end
   end

   // Registered outputs, forced low under reset
   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         horizontal_sync_o  <= 1'b0;
         vertical_sync_o    <= 1'b0;
         active_area_flag_o <= 1'b0;
         refresh_address_o  <= 14'h0000;
         char_line_index_o  <= 5'h00;
         cursor_o           <= 1'b0;
      end else begin
         horizontal_sync_o  <= hsync_active;
         vertical_sync_o    <= vsync_active;
         active_area_flag_o <= hdisp_active && vdisp_active;
         refresh_address_o  <= line_addr;
         // Video interlace shows even lines in one field, odd in the other
         if (regs.interlace[1:0] == `IL_VIDEO_MODE) begin
            char_line_index_o <= {scan_line[3:0], odd_field};
         end else begin
            char_line_index_o <= scan_line;
         end
         cursor_o <= (line_addr == regs.cur_addr) && hdisp_active && vdisp_active
                     && in_range(scan_line, regs.cur_start[4:0], regs.cur_end)
                     && blink_visible;
      end
   end

   // Host controls are asynchronous to the character clock, two flops first
   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_sync <= 2'h0;
      end else begin
         read_sync <= {read_sync[0], !bus_i.chip_select_n && bus_i.register_select
                       && bus_i.read_not_write && bus_strobe_i};
      end
   end

   // Host read data, driven only during a selected read
   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         data_o    <= 8'h00;
         data_oe_o <= 1'b0;
      end else begin
         data_o    <= read_data;
         data_oe_o <= read_sync[1];
      end
   end
endmodule

/* raster_timing_checks_assertions.sv */
`timescale 1ns/1ps
module raster_timing_checks (
   // Clock and reset
   input wire logic                         ref_clk_i,
   input wire logic                         rst_i,
   // Host port
   input wire logic                         bus_strobe_i,
   input wire raster_timing_pkg::host_bus_s bus_i,
   input wire logic [7:0]                   data_o,
   input wire logic                         data_oe_o,
   // Display outputs
   input wire logic                         horizontal_sync_o,
   input wire logic                         vertical_sync_o,
   input wire logic                         active_area_flag_o,
   input wire raster_timing_pkg::addr14_t   refresh_address_o,
   input wire logic [4:0]                   char_line_index_o,
   input wire logic                         cursor_o
);
   import raster_timing_pkg::*;
   logic [7:0] hs_len;
   default clocking cb @(negedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Saturates so a stuck sync cannot wrap back under the limit
   always_ff @(negedge ref_clk_i or posedge rst_i) begin
      if (rst_i)
         hs_len <= 8'h00;
      else if (!horizontal_sync_o)
         hs_len <= 8'h00;
      else if (hs_len != 8'hFF)
         hs_len <= hs_len + 8'h01;
   end
   sequence s_two_active;
      active_area_flag_o ##1 active_area_flag_o;
   endsequence
   a_reset_outputs_low: assert property (@(negedge ref_clk_i) disable iff (1'b0)
      rst_i |-> !(horizontal_sync_o | vertical_sync_o | active_area_flag_o | cursor_o
      | data_oe_o) && refresh_address_o == 14'h0000 && char_line_index_o == 5'h00)
      else $error("outputs active during reset");
   a_bus_drive_read: assert property (data_oe_o |-> $past(!bus_i.chip_select_n &&
      bus_i.register_select && bus_i.read_not_write && bus_strobe_i, 3))
      else $error("data bus driven outside a read");
   a_hsync_width: assert property (hs_len <= 8'h0F)
      else $error("horizontal sync wider than fifteen characters");
   a_addr_step: assert property (s_two_active |->
      refresh_address_o == addr14_t'($past(refresh_address_o) + 14'h0001))
      else $error("refresh address did not step by one");
   a_line_hold: assert property ($changed(char_line_index_o) |->
      !$past(active_area_flag_o)) else $error("line index changed inside a line");
   a_cursor_in_active: assert property (cursor_o |-> active_area_flag_o)
      else $error("cursor outside active area");
   a_active_no_hsync: assert property (active_area_flag_o |-> !horizontal_sync_o)
      else $error("sync during active area");
   a_vsync_no_active: assert property (vertical_sync_o |-> !active_area_flag_o)
      else $error("active area during vertical sync");
endmodule

bind crt_raster_timing_controller raster_timing_checks i_checks (.ref_clk_i, .rst_i,
   .bus_strobe_i, .bus_i, .data_o, .data_oe_o, .horizontal_sync_o, .vertical_sync_o,
   .active_area_flag_o, .refresh_address_o, .char_line_index_o, .cursor_o);

/* host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
   // Clock the host strobe is derived from
   input  wire logic                  ref_clk_i,
   // Bus toward the device
   output logic                       bus_strobe_o,
   output raster_timing_pkg::host_bus_s bus_o,
   // Device read side
   input  wire logic [7:0]            data_i,
   input  wire logic                  data_oe_i
);
   initial begin
      bus_strobe_o = 1'b0;
      bus_o = '{chip_select_n:1'b1, register_select:1'b0, read_not_write:1'b1, data:8'hA5};
   end
   task automatic access(input logic rs, input logic rw, input logic [7:0] wd,
                         output logic [7:0] rd, output logic oe);
      @(posedge ref_clk_i);
      // Selects and data stay put until after the strobe has fallen
      bus_o <= '{chip_select_n:1'b0, register_select:rs, read_not_write:rw,
                 data:(rw ? ~bus_o.data : wd)};
      bus_strobe_o <= 1'b1;
      // Read enable passes two sync flops and an output flop
      repeat (4) @(posedge ref_clk_i);
      rd = data_i;
      oe = data_oe_i;
      bus_strobe_o <= 1'b0;
      @(posedge ref_clk_i);
      // Released select and data lines show the inverse; read_not_write returns high
      bus_o <= '{chip_select_n:1'b1, register_select:~rs, read_not_write:1'b1,
                 data:~bus_o.data};
   endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
   import raster_timing_pkg::*;
   logic       ref_clk_i;
   logic       rst_i;
   logic       bus_strobe_i;
   host_bus_s  bus_i;
   logic [7:0] data_o;
   logic       data_oe_o;
   logic       light_pen_strobe_i;
   logic       hs;
   logic       vs;
   logic       act;
   logic       cur;
   addr14_t    ref_addr;
   logic [4:0] line_idx;
   addr14_t    start;
   addr14_t    cpos;
   addr14_t    pen_a;
   logic [7:0] rv;
   logic [7:0] lo;
   logic       oe;
   logic [4:0] cs_line;
   logic [4:0] ce_line;
   logic [7:0] cfg [16];
   int         n_fail;
   int         check_count;
   int         n;
   int         k;
   int         i;
   int         vis;

   crt_raster_timing_controller i_dut (.ref_clk_i, .rst_i, .bus_strobe_i, .bus_i, .data_o,
      .data_oe_o, .light_pen_strobe_i, .horizontal_sync_o(hs), .vertical_sync_o(vs),
      .active_area_flag_o(act), .refresh_address_o(ref_addr), .char_line_index_o(line_idx),
      .cursor_o(cur));
   host_bus_model i_host (.ref_clk_i, .bus_strobe_o(bus_strobe_i), .bus_o(bus_i),
      .data_i(data_o), .data_oe_i(data_oe_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return hs;
         1: return vs;
         2: return act;
         default: return cur;
      endcase
   endfunction

   // Counts cycles while the chosen output holds a level
   task automatic run_len(input int s, input logic lvl, output int len);
      len = 0;
      while (pick(s) === lvl) begin
         @(posedge ref_clk_i);
         len++;
         if (len > 2000) begin
            n_fail++;
            print_verdict();
         end
      end
   endtask

   task automatic to_rise(input int s);
      int d;
      run_len(s, 1'b1, d);
      run_len(s, 1'b0, d);
   endtask

   task automatic wr(input logic [4:0] idx, input logic [7:0] v);
      i_host.access(1'b0, 1'b0, {3'h0, idx}, rv, oe);
      i_host.access(1'b1, 1'b0, v, rv, oe);
   endtask

   task automatic rd(input logic [4:0] idx);
      i_host.access(1'b0, 1'b0, {3'h0, idx}, rv, oe);
      i_host.access(1'b1, 1'b1, 8'h00, rv, oe);
   endtask

   // One whole frame, vertical sync end to next sync start
   task automatic frame_cursor(output int cnt);
      int w;
      cnt = 0;
      run_len(1, 1'b1, w);
      for (w = 0; vs !== 1'b1; w++) begin
         if (cur === 1'b1) begin
            cnt++;
            check_val("cursor address", {2'h0, cpos}, {2'h0, ref_addr});
         end
         @(posedge ref_clk_i);
         if (w > 2000) begin
            n_fail++;
            print_verdict();
         end
      end
   endtask

   initial begin
      n_fail = 0;
      check_count = 0;
      rst_i = 1'b1;
      light_pen_strobe_i = 1'b0;
      k = $urandom(32'hFA63);
      start = addr14_t'($urandom);
      cpos = start + addr14_t'(8'h08 * $urandom_range(4, 0) + $urandom_range(7, 0));
      cs_line = 5'($urandom_range(3, 0));
      ce_line = 5'($urandom_range(3, cs_line));
      cfg = '{8'h0F, 8'h08, 8'h0A, 8'h03, 8'h09, 8'($urandom_range(3, 0)), 8'h05, 8'h06,
              8'h00, 8'h03, {3'h0, cs_line}, {3'h0, ce_line}, {2'h0, start[13:8]},
              start[7:0], {2'h0, cpos[13:8]}, cpos[7:0]};
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 16; i++)
         wr(i[4:0], cfg[i]);
      wr(5'h12, 8'hFF);
      to_rise(0);
      run_len(0, 1'b1, n);
      check_val("hsync width", 16'h0003, 16'(n));
      run_len(0, 1'b0, k);
      check_val("line period", 16'h0010, 16'(n + k));
      to_rise(2);
      run_len(2, 1'b1, n);
      check_val("active width", 16'h0008, 16'(n));
      to_rise(1);
      run_len(1, 1'b1, n);
      check_val("vsync width", 16'h0100, 16'(n));
      run_len(1, 1'b0, k);
      check_val("frame period", 16'(16 * (40 + cfg[5])), 16'(n + k));
      for (i = 0; i < 5; i++) begin
         to_rise(2);
         check_val("line start", {2'h0, start + (i == 4 ? 14'h0008 : 14'h0000)},
                   {2'h0, ref_addr});
         check_val("line index", 16'(i % 4), {11'h000, line_idx});
      end
      rd(5'h0E);
      check_val("cursor high", {10'h000, cpos[13:8]}, {8'h00, rv});
      check_val("read enable", 16'h0001, {15'h0000, oe});
      rd(5'h0F);
      check_val("cursor low", {8'h00, cpos[7:0]}, {8'h00, rv});
      rd(5'h00);
      check_val("total readback", 16'h0000, {8'h00, rv});
      to_rise(1);
      for (i = 0; i < 4; i++) begin
         wr(5'h0A, {1'b0, i[1:0], cs_line});
         vis = 0;
         repeat (i < 2 ? 2 : 8 << i) begin
            frame_cursor(n);
            if (n > 0)
               vis++;
            check_val("cursor height", (n == 0) ? 16'h0000 : 16'(ce_line - cs_line + 1), 16'(n));
         end
         check_val("blink frames", (i == 1) ? 16'h0000 : 16'(i < 2 ? 2 : 4 << i), 16'(vis));
      end
      to_rise(2);
      light_pen_strobe_i <= 1'b1;
      pen_a = ref_addr;
      repeat (8) @(posedge ref_clk_i);
      light_pen_strobe_i <= 1'b0;
      rd(5'h11);
      lo = rv;
      rd(5'h10);
      check_val("pen offset", 16'h0001, 16'(addr14_t'({rv[5:0], lo} - pen_a) <= 14'h0008));
      wr(5'h11, ~lo);
      rd(5'h11);
      check_val("pen after write", {8'h00, lo}, {8'h00, rv});
      wr(5'h08, 8'h01);
      to_rise(1);
      to_rise(2);
      n = line_idx;
      to_rise(1);
      to_rise(2);
      check_val("interlace index", 16'(n ^ 1), {11'h000, line_idx});
      wr(5'h08, 8'h00);
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      check_val("reset outputs", 16'h0000, {hs, vs, act, cur, ref_addr[11:0]});
      rst_i <= 1'b0;
      to_rise(0);
      run_len(0, 1'b1, n);
      run_len(0, 1'b0, k);
      check_val("period after reset", 16'h0010, 16'(n + k));
      rd(5'h0F);
      check_val("cursor kept", {8'h00, cpos[7:0]}, {8'h00, rv});
      print_verdict();
   end
endmodule
